// ---- logic/vnr_pkg.sv ----
package vnr_pkg;

	// ----------------------------------------------------------------
	// register sub addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_MEAS_CTRL   = 8'h14;
	localparam logic [7:0] ADDR_SENS        = 8'h15;
	localparam logic [7:0] ADDR_VOFF        = 8'h16;
	localparam logic [7:0] ADDR_FIXED_K     = 8'h17;
	localparam logic [7:0] ADDR_LUMA_ADAPT  = 8'h18;
	localparam logic [7:0] ADDR_CHROMA_ADPT = 8'h19;
	localparam logic [7:0] ADDR_ENABLES     = 8'h1A;
	localparam logic [7:0] ADDR_NOISE_LEVEL = 8'h7A;
	localparam logic [7:0] ADDR_NOISE_STAT  = 8'h7C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MEAS_ALG_BIT    = 7;
	localparam int ADAPT_BIT       = 7;
	localparam int CK_SRC_BIT      = 6;
	localparam int SPATIAL_EN_BIT  = 2;
	localparam int TEMPORAL_EN_BIT = 1;
	localparam int FB_DELAY_BIT    = 0;
	localparam int UPDATE_FLAG_BIT = 0;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_MEAS_CTRL = 8'h00;
	localparam logic [7:0] RST_SENS      = 8'h00;
	localparam logic [7:0] RST_VOFF      = 8'h00;
	localparam logic [7:0] RST_FIXED_K   = 8'hFF;
	localparam logic [7:0] RST_ADAPT     = 8'h80;
	localparam logic [7:0] RST_ENABLES   = 8'h00;

	// ----------------------------------------------------------------
	// filter and measurement constants
	// ----------------------------------------------------------------
	localparam logic [7:0]  HOMOG_THR     = 8'h08;
	localparam logic [10:0] MOTION_SAT    = 11'h03C;
	localparam logic [3:0]  K_MAX         = 4'hF;
	localparam logic [4:0]  LEVEL_MAX     = 5'h1E;
	localparam logic [4:0]  LEVEL_OVF     = 5'h1F;
	localparam logic [8:0]  LINE_A_FIRST  = 9'h001;
	localparam logic [8:0]  LINE_B_FIRST  = 9'h139;
	localparam logic [8:0]  MEAS_A_BASE   = 9'h003;
	localparam logic [8:0]  MEAS_B_BASE   = 9'h13C;
	localparam int          LEVEL_SHIFT   = 7;
	localparam logic [1:0]  AVG_LAST      = 2'h3;

endpackage

// ---- logic/vnr_core.sv ----
`timescale 1ns/100ps

// Operation
// - smooth luma with low-pass only where the neighbourhood is homogeneous
// - spatial enable bit in 1Ah switches luma spatial smoothing on or off
// - luma out = ref + (1+K)/16 times (spatial input minus ref)
// - chroma uses the same recursion, K from luma or chroma detector
// - motion detector gives four-bit K, 0 no motion, 15 full motion
// - chroma K source bit in 18h: 0 luma detector, 1 chroma detector
// - feedback delay bit in 1Ah: 1 one-field, 0 one-frame reference
// - temporal enable bit: 0 bypasses luma and chroma recursion
// - adaptive bits in 18h/19h: 0 fixed K, 1 motion-adaptive K
// - fixed K nibbles in 17h set K directly, 0 strongest, 15 none
// - signed -32..31 offset shifts the K curve along motion axis
// - signed -8..7 offset in 16h shifts the K curve along K axis
// - sensitivity nibbles in 15h, 0 least sensitive, 15 most
// - five-bit noise level at 7Ah, 0..30 linear, 31 means overflow
// - algorithm bit in 14h: 1 blanking line, 0 first active line
// - reported noise level is an average over several fields
// - line setting N picks line 3+N+D in field A, 316+N+D in field B, D the input vertical delay
// - status bit at 7Ch reads 1 when a new noise level is ready
// - spatial smoothing on luma only, temporal structure same both paths
module vnr_core
	import vnr_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// register access by sub address
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// picture timing
	input  wire logic       field_start_i,
	input  wire logic       field_b_i,
	input  wire logic       line_start_i,
	input  wire logic       active_i,
	input  wire logic [5:0] input_vertical_delay_i,
	// incoming pixels
	input  wire logic       pix_valid_i,
	input  wire logic [7:0] luma_i,
	input  wire logic [7:0] chroma_i,
	// delayed pictures from field memory
	input  wire logic [7:0] ref_field_luma_i,
	input  wire logic [7:0] ref_field_chroma_i,
	input  wire logic [7:0] ref_frame_luma_i,
	input  wire logic [7:0] ref_frame_chroma_i,
	// filtered pixels
	output logic            pix_valid_o,
	output logic      [7:0] luma_o,
	output logic      [7:0] chroma_o
);

	// ----------------------------------------------------------------
	// arithmetic helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] vnr_absdiff(input logic [7:0] a,
		input logic [7:0] b);
		vnr_absdiff = (a > b) ? (a - b) : (b - a);
	endfunction

	// fixed curve: linear in motion/4, saturating at full motion
	function automatic logic [3:0] vnr_kcurve(input logic [7:0] diff,
		input logic [3:0] sens, input logic [5:0] hoff,
		input logic [3:0] voff);
		logic signed [10:0] m;
		logic signed [6:0]  k;
		m = $signed({3'b000, diff}) + $signed({5'b00000, sens, 2'b00});
		m = m - $signed({{5{hoff[5]}}, hoff});
		if (m < 0) begin
			m = 11'sh000;
		end
		if (m >= $signed(MOTION_SAT)) begin
			k = $signed({3'b000, K_MAX});
		end else begin
			k = $signed({3'b000, m[5:2]});
		end
		k = k + $signed({{3{voff[3]}}, voff});
		if (k < 0) begin
			k = 7'sh00;
		end else if (k > $signed({3'b000, K_MAX})) begin
			k = $signed({3'b000, K_MAX});
		end
		vnr_kcurve = k[3:0];
	endfunction

	// first-order recursion with rounding and clipping
	function automatic logic [7:0] vnr_recurse(input logic [7:0] x,
		input logic [7:0] r, input logic [3:0] k);
		logic signed [8:0]  d;
		logic signed [14:0] p;
		logic signed [10:0] o;
		d = $signed({1'b0, x}) - $signed({1'b0, r});
		p = 15'(d * $signed({1'b0, 5'({1'b0, k} + 5'h01)}));
		o = $signed({3'b000, r}) + 11'((p + 15'sh0008) >>> 4);
		if (o < 0) begin
			vnr_recurse = 8'h00;
		end else if (o > 11'sh0FF) begin
			vnr_recurse = 8'hFF;
		end else begin
			vnr_recurse = o[7:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	logic [7:0] meas_ctrl_r;
	logic [7:0] sens_r;
	logic [7:0] voff_r;
	logic [7:0] fixed_k_r;
	logic [7:0] luma_adapt_r;
	logic [7:0] chroma_adapt_r;
	logic [7:0] enables_r;
	logic [4:0] noise_level_r;
	logic       update_flag_r;

	wire wr_meas   = reg_wr_i && (reg_addr_i == ADDR_MEAS_CTRL);
	wire wr_sens   = reg_wr_i && (reg_addr_i == ADDR_SENS);
	wire wr_voff   = reg_wr_i && (reg_addr_i == ADDR_VOFF);
	wire wr_fixk   = reg_wr_i && (reg_addr_i == ADDR_FIXED_K);
	wire wr_ladapt = reg_wr_i && (reg_addr_i == ADDR_LUMA_ADAPT);
	wire wr_cadapt = reg_wr_i && (reg_addr_i == ADDR_CHROMA_ADPT);
	wire wr_en     = reg_wr_i && (reg_addr_i == ADDR_ENABLES);
	wire rd_status = reg_rd_i && (reg_addr_i == ADDR_NOISE_STAT);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meas_ctrl_r    <= RST_MEAS_CTRL;
			sens_r         <= RST_SENS;
			voff_r         <= RST_VOFF;
			fixed_k_r      <= RST_FIXED_K;
			luma_adapt_r   <= RST_ADAPT;
			chroma_adapt_r <= RST_ADAPT;
			enables_r      <= RST_ENABLES;
		end else begin
			if (wr_meas)   meas_ctrl_r    <= reg_wdata_i;
			if (wr_sens)   sens_r         <= reg_wdata_i;
			if (wr_voff)   voff_r         <= reg_wdata_i;
			if (wr_fixk)   fixed_k_r      <= reg_wdata_i;
			if (wr_ladapt) luma_adapt_r   <= reg_wdata_i;
			if (wr_cadapt) chroma_adapt_r <= reg_wdata_i;
			if (wr_en)     enables_r      <= reg_wdata_i;
		end
	end

	// write-only setup registers read back as zero
	logic [7:0] rdata_nxt;
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_addr_i == ADDR_NOISE_LEVEL) begin
			rdata_nxt = {3'b000, noise_level_r};
		end else if (reg_addr_i == ADDR_NOISE_STAT) begin
			rdata_nxt = 8'h00;
			rdata_nxt[UPDATE_FLAG_BIT] = update_flag_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// field decode of settings
	// ----------------------------------------------------------------
	wire       spatial_filter_enable  = enables_r[SPATIAL_EN_BIT];
	wire       temporal_filter_enable = enables_r[TEMPORAL_EN_BIT];
	wire       feedback_delay_select  = enables_r[FB_DELAY_BIT];
	wire       chroma_k_source_select = luma_adapt_r[CK_SRC_BIT];
	wire       adaptive_k_select_y    = luma_adapt_r[ADAPT_BIT];
	wire       adaptive_k_select_c    = chroma_adapt_r[ADAPT_BIT];
	wire [5:0] hoff_y                 = luma_adapt_r[5:0];
	wire [5:0] hoff_c                 = chroma_adapt_r[5:0];
	wire       measure_algorithm_select = meas_ctrl_r[MEAS_ALG_BIT];
	wire [5:0] measure_line_select    = meas_ctrl_r[5:0];

	// one-field or one-frame reference
	wire [7:0] ref_y_sel = feedback_delay_select ? ref_field_luma_i
		: ref_frame_luma_i;
	wire [7:0] ref_c_sel = feedback_delay_select ? ref_field_chroma_i
		: ref_frame_chroma_i;

	// ----------------------------------------------------------------
	// input delay line, one pixel of look-ahead for the spatial taps
	// ----------------------------------------------------------------
	logic [7:0] y_cur_r;
	logic [7:0] y_prev_r;
	logic [7:0] c_cur_r;
	logic [7:0] ref_y_r;
	logic [7:0] ref_c_r;
	logic       have_cur_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			y_cur_r    <= 8'h00;
			y_prev_r   <= 8'h00;
			c_cur_r    <= 8'h00;
			ref_y_r    <= 8'h00;
			ref_c_r    <= 8'h00;
			have_cur_r <= 1'b0;
		end else if (pix_valid_i) begin
			y_cur_r    <= luma_i;
			y_prev_r   <= have_cur_r ? y_cur_r : luma_i;
			c_cur_r    <= chroma_i;
			ref_y_r    <= ref_y_sel;
			ref_c_r    <= ref_c_sel;
			have_cur_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// spatial filter, luma only
	// ----------------------------------------------------------------
	// a homogeneity test on both neighbours keeps edges sharp
	wire       homog = (vnr_absdiff(luma_i, y_cur_r) <= HOMOG_THR) &&
		(vnr_absdiff(y_prev_r, y_cur_r) <= HOMOG_THR);
	wire [9:0] smooth_sum = {2'b00, y_prev_r} + {1'b0, y_cur_r, 1'b0}
		+ {2'b00, luma_i} + 10'h002;
	wire [7:0] y_snr = (spatial_filter_enable && homog) ? smooth_sum[9:2]
		: y_cur_r;

	// ----------------------------------------------------------------
	// motion detectors and K selection
	// ----------------------------------------------------------------
	wire [3:0] k_motion_y = vnr_kcurve(vnr_absdiff(y_snr, ref_y_r),
		sens_r[3:0], hoff_y, voff_r[3:0]);
	wire [3:0] k_motion_c = vnr_kcurve(vnr_absdiff(c_cur_r, ref_c_r),
		sens_r[7:4], hoff_c, voff_r[7:4]);
	wire [3:0] luma_k_factor = adaptive_k_select_y ? k_motion_y
		: fixed_k_r[3:0];
	wire [3:0] k_chroma_adapt = chroma_k_source_select ? k_motion_c
		: k_motion_y;
	wire [3:0] chroma_k = adaptive_k_select_c ? k_chroma_adapt
		: fixed_k_r[7:4];

	wire [7:0] y_tnr = vnr_recurse(y_snr, ref_y_r, luma_k_factor);
	wire [7:0] c_tnr = vnr_recurse(c_cur_r, ref_c_r, chroma_k);

	// ----------------------------------------------------------------
	// output stage
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pix_valid_o <= 1'b0;
			luma_o      <= 8'h00;
			chroma_o    <= 8'h00;
		end else begin
			pix_valid_o <= pix_valid_i && have_cur_r;
			if (pix_valid_i && have_cur_r) begin
				luma_o   <= temporal_filter_enable ? y_tnr : y_snr;
				chroma_o <= temporal_filter_enable ? c_tnr : c_cur_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// noise measurement line tracking
	// ----------------------------------------------------------------
	logic [8:0] line_cnt_r;
	logic       field_b_r;
	logic       first_done_r;
	logic       meas_on_r;
	logic [15:0] meas_sum_r;
	logic [7:0] meas_pix_r;

	wire [8:0] line_cnt_nxt = line_cnt_r + 9'h001;
	wire [8:0] meas_target = (field_b_r ? MEAS_B_BASE : MEAS_A_BASE)
		+ {3'b000, measure_line_select}
		+ {3'b000, input_vertical_delay_i};
	wire       vbi_hit = measure_algorithm_select &&
		(line_cnt_nxt == meas_target);
	// first active line mode relies on a frame reference being chosen
	wire       act_hit = !measure_algorithm_select && active_i &&
		pix_valid_i && !first_done_r && !meas_on_r;
	wire       meas_done = line_start_i && meas_on_r;
	wire [7:0] meas_diff = vnr_absdiff(luma_i, ref_y_sel);
	wire [15:0] meas_lvl = meas_sum_r >> LEVEL_SHIFT;
	wire       lvl_ovf = (meas_lvl > {11'h000, LEVEL_MAX});

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			line_cnt_r   <= LINE_A_FIRST;
			field_b_r    <= 1'b0;
			first_done_r <= 1'b0;
			meas_on_r    <= 1'b0;
			meas_sum_r   <= 16'h0000;
			meas_pix_r   <= 8'h00;
		end else if (field_start_i) begin
			line_cnt_r   <= field_b_i ? LINE_B_FIRST : LINE_A_FIRST;
			field_b_r    <= field_b_i;
			first_done_r <= 1'b0;
			meas_on_r    <= 1'b0;
		end else begin
			if (line_start_i) begin
				line_cnt_r <= line_cnt_nxt;
				meas_on_r  <= vbi_hit;
			end else if (act_hit) begin
				meas_on_r    <= 1'b1;
				first_done_r <= 1'b1;
			end
			if (line_start_i && vbi_hit) begin
				meas_sum_r <= 16'h0000;
				meas_pix_r <= 8'h00;
			end else if (act_hit) begin
				// the opening pixel of the active line counts too
				meas_sum_r <= {8'h00, meas_diff};
				meas_pix_r <= 8'h01;
			end else if (meas_on_r && pix_valid_i && meas_pix_r != 8'hFF) begin
				// sample count capped so the sum cannot wrap
				meas_sum_r <= meas_sum_r + {8'h00, meas_diff};
				meas_pix_r <= meas_pix_r + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// averaging over fields and readout flag
	// ----------------------------------------------------------------
	logic [1:0] avg_cnt_r;
	logic [6:0] avg_acc_r;
	logic       avg_ovf_r;

	wire [4:0] lvl_clip = lvl_ovf ? LEVEL_MAX : meas_lvl[4:0];
	wire [6:0] avg_total = avg_acc_r + {2'b00, lvl_clip};
	wire       avg_ready = meas_done && (avg_cnt_r == AVG_LAST);

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			avg_cnt_r     <= 2'h0;
			avg_acc_r     <= 7'h00;
			avg_ovf_r     <= 1'b0;
			noise_level_r <= 5'h00;
		end else if (meas_done) begin
			avg_cnt_r <= avg_cnt_r + 2'h1;
			if (avg_ready) begin
				avg_acc_r     <= 7'h00;
				avg_ovf_r     <= 1'b0;
				noise_level_r <= (avg_ovf_r || lvl_ovf) ? LEVEL_OVF
					: avg_total[6:2];
			end else begin
				avg_acc_r <= avg_total;
				avg_ovf_r <= avg_ovf_r || lvl_ovf;
			end
		end
	end

	// a fresh result in the same cycle as the read keeps the flag set
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			update_flag_r <= 1'b0;
		end else if (avg_ready) begin
			update_flag_r <= 1'b1;
		end else if (rd_status) begin
			update_flag_r <= 1'b0;
		end
	end

endmodule

// ---- verif/vnr_core_asserts.sv ----
`timescale 1ns/100ps

module vnr_core_asserts
	import vnr_pkg::*;
(
	// clock and reset
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// pixel stream
	input wire logic       line_start_i,
	input wire logic       pix_valid_i,
	input wire logic [7:0] luma_i,
	input wire logic [7:0] chroma_i,
	input wire logic       pix_valid_o,
	input wire logic [7:0] luma_o,
	input wire logic [7:0] chroma_o
);
	logic [2:0] en_r;
	logic [7:0] y0_r;
	logic [7:0] y1_r;
	logic [7:0] c0_r;
	logic [7:0] c1_r;
	wire logic       rd_stat = reg_rd_i && reg_addr_i == ADDR_NOISE_STAT;
	wire logic       rd_lvl  = reg_rd_i && reg_addr_i == ADDR_NOISE_LEVEL;
	wire logic       rd_wo   = reg_rd_i && reg_addr_i >= ADDR_MEAS_CTRL
		&& reg_addr_i <= ADDR_ENABLES;
	wire logic       t_off   = !en_r[TEMPORAL_EN_BIT];
	wire logic [7:0] dn      = y0_r > y1_r ? y0_r - y1_r : y1_r - y0_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			en_r <= 3'h0;
		else if (reg_wr_i && reg_addr_i == ADDR_ENABLES)
			en_r <= reg_wdata_i[2:0];
	end

	// output n leaves after pixel n+1, so keep two taps
	always_ff @(posedge clk_i) begin
		if (pix_valid_i) begin
			y0_r <= luma_i;
			y1_r <= y0_r;
			c0_r <= chroma_i;
			c1_r <= c0_r;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_idle;
		(!line_start_i && !pix_valid_i)[*4];
	endsequence
	sequence s_rd_stat;
		rd_stat && !line_start_i;
	endsequence

	a_rdata_hold: assert property (
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	a_level_width: assert property (
		rd_lvl |=> reg_rdata_o[7:5] == 3'h0)
		else $error("noise level wider than five bits");
	a_stat_width: assert property (
		rd_stat |=> reg_rdata_o[7:1] == 7'h00)
		else $error("status read has stray bits");
	a_flag_clear: assert property (
		s_idle ##1 s_rd_stat ##1 !line_start_i ##1 rd_stat
		|=> !reg_rdata_o[0])
		else $error("update flag not cleared by read");
	a_wo_zero: assert property (
		rd_wo |=> reg_rdata_o == 8'h00)
		else $error("write-only place read nonzero");
	a_out_cause: assert property (
		pix_valid_o |-> $past(pix_valid_i))
		else $error("output pixel without input pixel");
	a_out_hold: assert property (
		!pix_valid_o |-> $stable(luma_o) && $stable(chroma_o))
		else $error("pixel data moved between strobes");
	a_bypass_luma: assert property (
		pix_valid_o && t_off && !en_r[2] |-> luma_o == y1_r)
		else $error("luma altered with filters off");
	a_chroma_raw: assert property (
		pix_valid_o && t_off |-> chroma_o == c1_r)
		else $error("chroma altered without temporal filter");
	a_detail_kept: assert property (
		pix_valid_o && t_off && dn > HOMOG_THR |-> luma_o == y1_r)
		else $error("detailed luma was smoothed");
endmodule

bind vnr_core vnr_core_asserts i_vnr_core_asserts (.*);

// ---- verif/vnr_video_src.sv ----
`timescale 1ns/100ps

module vnr_video_src (
	// clock
	input  wire logic       clk_i,
	// picture timing
	output logic            field_start_o,
	output logic            field_b_o,
	output logic            line_start_o,
	output logic            active_o,
	// pixels and delayed pictures
	output logic            pix_valid_o,
	output logic      [7:0] luma_o,
	output logic      [7:0] chroma_o,
	output logic      [7:0] fld_luma_o,
	output logic      [7:0] fld_chroma_o,
	output logic      [7:0] frm_luma_o,
	output logic      [7:0] frm_chroma_o
);
	initial begin
		{field_start_o, field_b_o, line_start_o, active_o} = 4'h0;
		{pix_valid_o, luma_o, chroma_o} = 17'h00000;
		{fld_luma_o, fld_chroma_o, frm_luma_o, frm_chroma_o} = 32'h0;
	end

	task automatic field(input logic b);
		@(posedge clk_i);
		field_b_o <= b;
		field_start_o <= 1'b1;
		@(posedge clk_i);
		field_start_o <= 1'b0;
	endtask

	task automatic line(input logic act);
		@(posedge clk_i);
		line_start_o <= 1'b1;
		active_o <= act;
		@(posedge clk_i);
		line_start_o <= 1'b0;
	endtask

	task automatic pix(input logic [7:0] y, c, f, r);
		@(posedge clk_i);
		pix_valid_o <= 1'b1;
		{luma_o, chroma_o} <= {y, c};
		{fld_luma_o, fld_chroma_o} <= {f, f};
		{frm_luma_o, frm_chroma_o} <= {r, r};
	endtask

	// released lines are inverted on every idle cycle
	task automatic idle();
		@(posedge clk_i);
		pix_valid_o <= 1'b0;
		{luma_o, chroma_o} <= ~{luma_o, chroma_o};
		fld_luma_o <= ~fld_luma_o;
		fld_chroma_o <= ~fld_chroma_o;
		frm_luma_o <= ~frm_luma_o;
		frm_chroma_o <= ~frm_chroma_o;
	endtask
endmodule

// ---- verif/vnr_core_tb_top.sv ----
`timescale 1ns/100ps

module vnr_core_tb_top
	import vnr_pkg::*;
;
	logic        clk_i       = 1'b0;
	logic        rst_n_i     = 1'b0;
	logic [7:0]  reg_addr_i  = 8'h00;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic        reg_wr_i    = 1'b0;
	logic        reg_rd_i    = 1'b0;
	logic [7:0]  reg_rdata_o;
	logic        pix_valid_o;
	logic [7:0]  luma_o;
	logic [7:0]  chroma_o;
	logic        fs;
	logic        fb;
	logic        ls;
	logic        act;
	logic        pv;
	logic [7:0]  y;
	logic [7:0]  c;
	logic [7:0]  fy;
	logic [7:0]  fc;
	logic [7:0]  ry;
	logic [7:0]  rc;
	logic [15:0] oq[$];
	int          miscompares = 0;
	int          check_count = 0;
	logic [7:0]  d;
	logic [7:0]  r;
	int          ky;
	int          kv;
	logic [7:0]  ra[5] = '{8'h7A, 8'h7C, 8'h14, 8'h1A, 8'h55};
	logic [3:0]  kf[3] = '{4'h0, 4'h7, 4'hF};
	logic [7:0]  sp[4] = '{8'h10, 8'h14, 8'h10, 8'h40};
	int          ts[3] = '{0, 0, 3};
	int          th[3] = '{0, 31, -32};
	int          tv[3] = '{0, -3, -8};
	int          tsel[3] = '{0, 1, 1};

	always #12.5 clk_i = ~clk_i;

	vnr_core i_vnr_core (
		.clk_i, .rst_n_i,
		.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.field_start_i(fs), .field_b_i(fb), .line_start_i(ls),
		.active_i(act), .input_vertical_delay_i(6'h00),
		.pix_valid_i(pv), .luma_i(y), .chroma_i(c),
		.ref_field_luma_i(fy), .ref_field_chroma_i(fc),
		.ref_frame_luma_i(ry), .ref_frame_chroma_i(rc),
		.pix_valid_o, .luma_o, .chroma_o
	);

	vnr_video_src i_vnr_video_src (
		.clk_i, .field_start_o(fs), .field_b_o(fb), .line_start_o(ls),
		.active_o(act), .pix_valid_o(pv), .luma_o(y), .chroma_o(c),
		.fld_luma_o(fy), .fld_chroma_o(fc),
		.frm_luma_o(ry), .frm_chroma_o(rc)
	);

	always @(posedge clk_i) begin
		if (pix_valid_o === 1'b1)
			oq.push_back({luma_o, chroma_o});
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, v);
		@(posedge clk_i);
		{reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, v, 1'b1};
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_i);
		{reg_addr_i, reg_rd_i} <= {a, 1'b1};
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask

	function automatic logic [7:0] tf(input int x, rf, k);
		int v;
		v = rf + (((x - rf) * (1 + k) + 8) >>> 4);
		return 8'(v < 0 ? 0 : v > 255 ? 255 : v);
	endfunction

	function automatic int kc(input int df, s, h, o);
		int m;
		m = df + 4 * s - h;
		m = m < 0 ? 0 : m;
		m = (m >= 60 ? 15 : m >> 2) + o;
		return m < 0 ? 0 : m > 15 ? 15 : m;
	endfunction

	task automatic run(input logic [7:0] a, b, f, g);
		oq.delete();
		repeat (3) i_vnr_video_src.pix(a, b, f, g);
		repeat (4) i_vnr_video_src.idle();
	endtask

	// six lines, the hit line differs from the rest by half
	task automatic nfield(input logic b, input int tgt, input int af);
		logic [7:0] v;
		i_vnr_video_src.field(b);
		for (int i = 1; i <= 6; i++) begin
			v = 8'h80 - (i == tgt ? 8'h20 : 8'h40);
			i_vnr_video_src.line(i >= af);
			repeat (16) i_vnr_video_src.pix(8'h80, 8'h80, v, v);
			i_vnr_video_src.idle();
		end
	endtask

	task automatic lvl_chk();
		repeat (4) i_vnr_video_src.idle();
		rd(ADDR_NOISE_LEVEL, d);
		chk(16'(d), 16'((16 * 32) >> LEVEL_SHIFT));
		rd(ADDR_NOISE_STAT, r);
		chk(16'(r), 16'h0001);
		rd(ADDR_NOISE_STAT, r);
		chk(16'(r), 16'h0000);
		wr(ADDR_FIXED_K, {2{d[3:0]}});
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		foreach (ra[i]) begin
			rd(ra[i], d);
			chk(16'(d), 16'h0000);
		end
		$display("test reset done");
		run(8'h10, 8'h50, 8'h40, 8'h90);
		chk(16'(oq.size()), 16'h0002);
		chk(oq[0], 16'h1050);
		$display("test bypass done");
		wr(ADDR_LUMA_ADAPT, 8'h00);
		wr(ADDR_CHROMA_ADPT, 8'h00);
		for (int dl = 0; dl < 2; dl++) begin
			foreach (kf[i]) begin
				wr(ADDR_ENABLES, {6'h00, 1'b1, 1'(dl)});
				wr(ADDR_FIXED_K, {kf[i], kf[i]});
				run(8'h80, 8'h20, 8'h40, 8'hC0);
				r = dl ? 8'h40 : 8'hC0;
				// oq[0] is the pixel left over from the previous run
				chk(oq[1], {tf(128, r, kf[i]), tf(32, r, kf[i])});
			end
		end
		$display("test fixed k done");
		wr(ADDR_ENABLES, 8'h02);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_SENS, {2{4'(ts[i])}});
			wr(ADDR_VOFF, {2{4'(tv[i])}});
			wr(ADDR_LUMA_ADAPT, {1'b1, 1'(tsel[i]), 6'(th[i])});
			wr(ADDR_CHROMA_ADPT, {2'h2, 6'(th[i])});
			run(8'h80, 8'h20, 8'h40, 8'h40);
			ky = kc(64, ts[i], th[i], tv[i]);
			kv = tsel[i] ? kc(32, ts[i], th[i], tv[i]) : ky;
			chk(oq[1], {tf(128, 64, ky), tf(32, 64, kv)});
		end
		$display("test adaptive k done");
		wr(ADDR_ENABLES, 8'h04);
		oq.delete();
		foreach (sp[i])
			i_vnr_video_src.pix(sp[i], 8'h33, 8'h00, 8'h00);
		repeat (4) i_vnr_video_src.idle();
		chk(oq[2], 16'h1233);
		chk(oq[3], 16'h1033);
		$display("test spatial done");
		wr(ADDR_MEAS_CTRL, 8'h82);
		for (int f = 0; f < 4; f++)
			nfield(f[0], f[0] ? 5 : 4, 7);
		lvl_chk();
		wr(ADDR_ENABLES, 8'h00);
		wr(ADDR_MEAS_CTRL, 8'h00);
		for (int f = 0; f < 4; f++)
			nfield(f[0], 3, 3);
		lvl_chk();
		$display("test measure done");
		wrap_up();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		wrap_up();
	end
endmodule
